// ### logic/mbf_dev_end.sv
// Device end: frame check, address filter and reply builder
//
// Behaviour
// RL1 - Character check: byte sum modulo 256
// RL2 - Character check: negated sum, high nibble first
// RL3 - Cyclic check register starts at all ones
// RL4 - Each byte folds into low check byte
// RL5 - Shift right, xor polynomial if lsb set
// RL6 - Eight shift steps per byte
// RL7 - Check covers address through last data
// RL8 - Binary check sent low byte first
// RL9 - Character frame ends with CR, LF
// RL10 - Binary frame ends after four idle characters
// RL11 - Address or value faults get exception reply
// RL12 - Bad check frames dropped without reply
// RL13 - Exception: address, function plus 80, code, check
// RL14 - Error codes 01 to 04
// RL15 - Broadcast address zero acted on, never answered
// RL16 - Own address 1 to 254 only
// RL17 - Read reply: byte count, words high first
// RL18 - Foreign address frames silently ignored
`timescale 1ns/1ns
`include "mbf_regs.svh"
module mbf_dev_end
  import mbf_pkg::*;
#(
  parameter int CHAR_CYC = (`MBF_CLK_HZ * `MBF_CHAR_BITS + `MBF_BAUD - 1) / `MBF_BAUD,
  parameter int MAXB     = `MBF_MAX_BYTES,
  parameter int AW       = $clog2(MAXB)
) (
  input  wire logic              CLK,
  input  wire logic              RST_N,
  input  wire logic              MODE_BIN,
  input  wire mbf_pkg::mbf_byte_t OWN_ADDR,
  input  wire logic [AW-1:0]     RD_IDX,
  input  wire logic              REPLY_GO,
  input  wire mbf_pkg::mbf_byte_t REPLY_CODE,
  input  wire mbf_pkg::mbf_byte_t PAY_BYTE,
  input  wire logic              PAY_LAST,
  output logic                   FRAME_OK,
  output logic                   NEED_REPLY,
  output logic                   FRAME_ERR,
  output logic [AW:0]            FRAME_LEN,
  output mbf_pkg::mbf_byte_t     RD_BYTE,
  output logic                   PAY_TAKE,
  output logic                   TX_BUSY,
  mbf_link_if.dev                LINK
);
  import mbf_pkg::*;

  localparam int IDLE_CYC = `MBF_IDLE_CHARS * CHAR_CYC;

  // ----------------------------------------
  // Receive side
  // ----------------------------------------
  logic [7:0]  buf_mem [MAXB];
  logic [AW:0] cnt_reg;
  logic        in_frame_reg;
  logic        half_reg;
  logic [3:0]  nib_reg;
  logic        cr_reg;
  logic        bad_reg;
  logic [15:0] crc_reg;
  logic [7:0]  lrc_reg;
  logic [31:0] idle_reg;

  wire [7:0] rx_ch     = LINK.h2d_data;
  wire       rx_stb    = LINK.h2d_stb;
  wire [4:0] hx        = mbf_hex_val(rx_ch);
  wire       is_start  = !MODE_BIN && rx_stb && rx_ch == `MBF_CH_START;
  wire       new_bin   = MODE_BIN && rx_stb && !in_frame_reg;
  wire       byte_ok   = in_frame_reg && rx_stb && (MODE_BIN || (hx[4] && half_reg));
  wire [7:0] byte_val  = MODE_BIN ? rx_ch : {nib_reg, hx[3:0]};
  wire       end_chr   = !MODE_BIN && in_frame_reg && rx_stb && cr_reg && rx_ch == `MBF_CH_LF; // RL9
  wire       end_bin   = MODE_BIN && in_frame_reg && !rx_stb && idle_reg == 32'(IDLE_CYC - 1); // RL10
  wire       frame_end = end_chr || end_bin;
  wire       room      = cnt_reg < (AW+1)'(MAXB);
  wire       wr_en     = room && (new_bin || (byte_ok && !is_start));
  wire [AW-1:0] wr_idx = new_bin ? '0 : cnt_reg[AW-1:0];
  wire [7:0] wr_val    = new_bin ? rx_ch : byte_val;
  wire       chk_bin   = crc_reg == 16'h0000 && cnt_reg >= (AW+1)'(`MBF_MIN_BIN); // RL7
  wire       chk_chr   = lrc_reg == 8'h00 && cnt_reg >= (AW+1)'(`MBF_MIN_CHR) && !half_reg; // RL1
  wire       chk_ok    = !bad_reg && (MODE_BIN ? chk_bin : chk_chr);
  wire [7:0] adr       = buf_mem[0];
  wire       own_ok    = OWN_ADDR != `MBF_BCAST && OWN_ADDR <= `MBF_ADR_MAX && adr == OWN_ADDR; // RL16

  always_ff @(posedge CLK) begin
    if (wr_en) begin
      buf_mem[wr_idx] <= wr_val;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      idle_reg <= 32'h0;
    end else if (rx_stb) begin
      idle_reg <= 32'h0;
    end else if (idle_reg != 32'(IDLE_CYC - 1)) begin
      idle_reg <= idle_reg + 32'h1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cnt_reg      <= '0;
      in_frame_reg <= 1'b0;
      half_reg     <= 1'b0;
      nib_reg      <= 4'h0;
      cr_reg       <= 1'b0;
      bad_reg      <= 1'b0;
      crc_reg      <= `MBF_CRC_INIT;
      lrc_reg      <= 8'h00;
    end else if (is_start) begin
      in_frame_reg <= 1'b1;
      cnt_reg      <= '0;
      lrc_reg      <= 8'h00;
      half_reg     <= 1'b0;
      cr_reg       <= 1'b0;
      bad_reg      <= 1'b0;
    end else if (new_bin) begin
      in_frame_reg <= 1'b1;
      cnt_reg      <= (AW+1)'(1);
      crc_reg      <= mbf_crc_byte(`MBF_CRC_INIT, rx_ch); // RL3
      bad_reg      <= 1'b0;
    end else if (frame_end) begin
      in_frame_reg <= 1'b0;
    end else if (byte_ok) begin
      cnt_reg  <= room ? cnt_reg + (AW+1)'(1) : cnt_reg;
      bad_reg  <= bad_reg | !room;
      crc_reg  <= mbf_crc_byte(crc_reg, byte_val); // RL7
      lrc_reg  <= 8'(lrc_reg + byte_val); // RL1
      half_reg <= 1'b0;
    end else if (in_frame_reg && rx_stb && !MODE_BIN) begin
      if (hx[4]) begin
        nib_reg  <= hx[3:0];
        half_reg <= 1'b1;
      end else if (rx_ch == `MBF_CH_CR) begin
        cr_reg <= 1'b1;
      end else begin
        bad_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Transmit side
  // ----------------------------------------
  mbf_tx_t     st_reg;
  logic [31:0] div_reg;
  logic        tnib_reg;
  logic [7:0]  hold_reg;
  logic        hold_last_reg;
  logic        exc_reg;
  logic [7:0]  code_reg;
  logic [AW:0] bidx_reg;
  logic [15:0] tcrc_reg;
  logic [7:0]  tlrc_reg;
  logic [2:0]  gap_reg;
  logic [7:0]  d2h_data_reg;
  logic        d2h_stb_reg;

  wire       tick      = div_reg == 32'(CHAR_CYC - 1);
  wire [7:0] func      = buf_mem[1];
  wire       is_read   = func == `MBF_FN_READ;
  wire [7:0] rd_count  = {buf_mem[5][6:0], 1'b0}; // RL17
  wire       user_now  = st_reg == T_BODY && !exc_reg && bidx_reg >= (is_read ? (AW+1)'(2) : (AW+1)'(1));
  wire [7:0] body_b0   = exc_reg ? (func | `MBF_EXC_FLAG) : func; // RL13
  wire [7:0] body_b1   = exc_reg ? code_reg : (is_read ? rd_count : PAY_BYTE); // RL14
  wire [7:0] body_b    = bidx_reg == '0 ? body_b0 : (bidx_reg == (AW+1)'(1) ? body_b1 : PAY_BYTE);
  wire [7:0] lrc_out   = 8'(8'h00 - tlrc_reg); // RL2
  wire [7:0] sel       = st_reg == T_ADR ? adr :
                         st_reg == T_BODY ? body_b :
                         st_reg == T_CHK0 ? (MODE_BIN ? tcrc_reg[7:0] : lrc_out) : tcrc_reg[15:8]; // RL8
  wire [7:0] cur       = tnib_reg ? hold_reg : sel;
  wire       cur_last  = tnib_reg ? hold_last_reg : PAY_LAST;
  wire       last_body = exc_reg ? bidx_reg == (AW+1)'(1) : (user_now && cur_last);
  wire [7:0] tx_chr    = MODE_BIN ? cur : mbf_hex_chr(tnib_reg ? cur[3:0] : cur[7:4]); // RL2
  wire       data_st   = st_reg == T_ADR || st_reg == T_BODY || st_reg == T_CHK0 || st_reg == T_CHK1;
  wire       byte_done = MODE_BIN || tnib_reg;
  wire       fold      = st_reg == T_ADR || st_reg == T_BODY;

  always_ff @(posedge CLK) begin
    if (!RST_N || st_reg == T_IDLE) begin
      div_reg <= 32'h0;
    end else begin
      div_reg <= tick ? 32'h0 : div_reg + 32'h1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st_reg        <= T_IDLE;
      tnib_reg      <= 1'b0;
      hold_reg      <= 8'h00;
      hold_last_reg <= 1'b0;
      exc_reg       <= 1'b0;
      code_reg      <= 8'h00;
      bidx_reg      <= '0;
      tcrc_reg      <= `MBF_CRC_INIT;
      tlrc_reg      <= 8'h00;
      gap_reg       <= 3'h0;
      d2h_data_reg  <= 8'h00;
      d2h_stb_reg   <= 1'b0;
      PAY_TAKE      <= 1'b0;
      FRAME_OK      <= 1'b0;
      FRAME_ERR     <= 1'b0;
      NEED_REPLY    <= 1'b0;
      FRAME_LEN     <= '0;
      TX_BUSY       <= 1'b0;
    end else begin
      d2h_stb_reg <= 1'b0;
      PAY_TAKE    <= 1'b0;
      FRAME_OK    <= 1'b0;
      FRAME_ERR   <= 1'b0;
      TX_BUSY     <= st_reg != T_IDLE;
      case (st_reg)
        T_IDLE: begin
          if (frame_end) begin
            FRAME_LEN <= cnt_reg - (MODE_BIN ? (AW+1)'(2) : (AW+1)'(1));
            if (!chk_ok) begin
              FRAME_ERR <= 1'b1; // RL12
            end else if (adr == `MBF_BCAST) begin
              FRAME_OK   <= 1'b1; // RL15
              NEED_REPLY <= 1'b0;
            end else if (own_ok) begin // RL18
              FRAME_OK   <= 1'b1;
              NEED_REPLY <= 1'b1;
              st_reg     <= T_WAIT;
            end
          end
        end
        T_WAIT: begin
          if (REPLY_GO) begin
            exc_reg    <= REPLY_CODE != `MBF_ERR_NONE; // RL11
            code_reg   <= REPLY_CODE;
            bidx_reg   <= '0;
            tnib_reg   <= 1'b0;
            tcrc_reg   <= `MBF_CRC_INIT; // RL3
            tlrc_reg   <= 8'h00;
            NEED_REPLY <= 1'b0;
            st_reg     <= MODE_BIN ? T_ADR : T_START;
          end
        end
        T_START: begin
          if (tick) begin
            d2h_stb_reg  <= 1'b1;
            d2h_data_reg <= `MBF_CH_START;
            st_reg       <= T_ADR;
          end
        end
        T_END: begin
          if (tick && !MODE_BIN) begin
            d2h_stb_reg  <= 1'b1;
            d2h_data_reg <= tnib_reg ? `MBF_CH_LF : `MBF_CH_CR; // RL9
            tnib_reg     <= !tnib_reg;
            st_reg       <= tnib_reg ? T_IDLE : T_END;
          end else if (tick) begin
            gap_reg <= 3'(gap_reg + 3'h1);
            if (gap_reg == 3'(`MBF_IDLE_CHARS - 1)) begin // RL10
              gap_reg <= 3'h0;
              st_reg  <= T_IDLE;
            end
          end
        end
        default: begin
          if (tick && data_st) begin
            d2h_stb_reg  <= 1'b1;
            d2h_data_reg <= tx_chr;
            if (!tnib_reg) begin
              hold_reg      <= sel;
              hold_last_reg <= PAY_LAST;
              PAY_TAKE      <= user_now;
            end
            if (!MODE_BIN) begin
              tnib_reg <= !tnib_reg;
            end
            if (byte_done) begin
              if (fold) begin
                tcrc_reg <= mbf_crc_byte(tcrc_reg, cur); // RL7
                tlrc_reg <= 8'(tlrc_reg + cur);
              end
              bidx_reg <= st_reg == T_BODY ? bidx_reg + (AW+1)'(1) : bidx_reg;
              case (st_reg)
                T_ADR:   st_reg <= T_BODY;
                T_BODY:  st_reg <= last_body ? T_CHK0 : T_BODY;
                T_CHK0:  st_reg <= MODE_BIN ? T_CHK1 : T_END;
                default: st_reg <= T_END;
              endcase
            end
          end else if (!data_st) begin
            st_reg <= T_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      RD_BYTE <= 8'h00;
    end else begin
      RD_BYTE <= buf_mem[RD_IDX];
    end
  end

  assign LINK.d2h_data = d2h_data_reg;
  assign LINK.d2h_stb  = d2h_stb_reg;
endmodule

// ### logic/mbf_host_end.sv
// Host controller end: request framing and reply checking
`timescale 1ns/1ns
`include "mbf_regs.svh"
module mbf_host_end
  import mbf_pkg::*;
#(
  parameter int CHAR_CYC = (`MBF_CLK_HZ * `MBF_CHAR_BITS + `MBF_BAUD - 1) / `MBF_BAUD,
  parameter int LW       = 6
) (
  input  wire logic               CLK,
  input  wire logic               RST_N,
  input  wire logic               MODE_BIN,
  input  wire logic               SEND,
  input  wire mbf_pkg::mbf_byte_t SEND_ADDR,
  input  wire mbf_pkg::mbf_byte_t PAY_BYTE,
  input  wire logic               PAY_LAST,
  output logic                    PAY_TAKE,
  output logic                    TX_BUSY,
  output logic                    RX_STB,
  output mbf_pkg::mbf_byte_t      RX_BYTE,
  output logic                    RX_DONE,
  output logic                    RX_GOOD,
  output logic [LW-1:0]           RX_LEN,
  mbf_link_if.host                LINK
);
  import mbf_pkg::*;

  localparam int IDLE_CYC = `MBF_IDLE_CHARS * CHAR_CYC;

  // ----------------------------------------
  // Reply receiver
  // ----------------------------------------
  logic [LW-1:0] cnt_reg;
  logic          in_frame_reg;
  logic          half_reg;
  logic [3:0]    nib_reg;
  logic          cr_reg;
  logic          bad_reg;
  logic [15:0]   crc_reg;
  logic [7:0]    lrc_reg;
  logic [31:0]   idle_reg;

  wire [7:0] rx_ch    = LINK.d2h_data;
  wire       rx_stb   = LINK.d2h_stb;
  wire [4:0] hx       = mbf_hex_val(rx_ch);
  wire       is_start = !MODE_BIN && rx_stb && rx_ch == `MBF_CH_START;
  wire       new_bin  = MODE_BIN && rx_stb && !in_frame_reg;
  wire       byte_ok  = in_frame_reg && rx_stb && (MODE_BIN || (hx[4] && half_reg));
  wire [7:0] byte_val = MODE_BIN ? rx_ch : {nib_reg, hx[3:0]};
  wire       end_chr  = !MODE_BIN && in_frame_reg && rx_stb && cr_reg && rx_ch == `MBF_CH_LF;
  wire       end_bin  = MODE_BIN && in_frame_reg && !rx_stb && idle_reg == 32'(IDLE_CYC - 1);
  wire       chk_bin  = crc_reg == 16'h0000 && cnt_reg >= LW'(`MBF_MIN_BIN);
  wire       chk_chr  = lrc_reg == 8'h00 && cnt_reg >= LW'(`MBF_MIN_CHR) && !half_reg;

  always_ff @(posedge CLK) begin
    if (!RST_N || rx_stb) begin
      idle_reg <= 32'h0;
    end else if (idle_reg != 32'(IDLE_CYC - 1)) begin
      idle_reg <= idle_reg + 32'h1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cnt_reg      <= '0;
      in_frame_reg <= 1'b0;
      half_reg     <= 1'b0;
      nib_reg      <= 4'h0;
      cr_reg       <= 1'b0;
      bad_reg      <= 1'b0;
      crc_reg      <= `MBF_CRC_INIT;
      lrc_reg      <= 8'h00;
      RX_STB       <= 1'b0;
      RX_BYTE      <= 8'h00;
      RX_DONE      <= 1'b0;
      RX_GOOD      <= 1'b0;
      RX_LEN       <= '0;
    end else begin
      RX_STB  <= 1'b0;
      RX_DONE <= 1'b0;
      if (is_start) begin
        in_frame_reg <= 1'b1;
        cnt_reg      <= '0;
        lrc_reg      <= 8'h00;
        half_reg     <= 1'b0;
        cr_reg       <= 1'b0;
        bad_reg      <= 1'b0;
      end else if (new_bin) begin
        in_frame_reg <= 1'b1;
        cnt_reg      <= LW'(1);
        crc_reg      <= mbf_crc_byte(`MBF_CRC_INIT, rx_ch); // RL3
        bad_reg      <= 1'b0;
        RX_STB       <= 1'b1;
        RX_BYTE      <= rx_ch;
      end else if (end_chr || end_bin) begin
        in_frame_reg <= 1'b0;
        RX_DONE      <= 1'b1; // RL10
        RX_GOOD      <= !bad_reg && (MODE_BIN ? chk_bin : chk_chr); // RL8
        RX_LEN       <= cnt_reg;
      end else if (byte_ok) begin
        cnt_reg  <= cnt_reg + LW'(1);
        crc_reg  <= mbf_crc_byte(crc_reg, byte_val); // RL7
        lrc_reg  <= 8'(lrc_reg + byte_val); // RL1
        half_reg <= 1'b0;
        RX_STB   <= 1'b1;
        RX_BYTE  <= byte_val;
      end else if (in_frame_reg && rx_stb && !MODE_BIN) begin
        if (hx[4]) begin
          nib_reg  <= hx[3:0];
          half_reg <= 1'b1;
        end else if (rx_ch == `MBF_CH_CR) begin
          cr_reg <= 1'b1; // RL9
        end else begin
          bad_reg <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Request sender
  // ----------------------------------------
  mbf_tx_t     st_reg;
  logic [31:0] div_reg;
  logic        tnib_reg;
  logic [7:0]  hold_reg;
  logic        hold_last_reg;
  logic [7:0]  adr_reg;
  logic [15:0] tcrc_reg;
  logic [7:0]  tlrc_reg;
  logic [2:0]  gap_reg;
  logic [7:0]  h2d_data_reg;
  logic        h2d_stb_reg;

  wire       tick     = div_reg == 32'(CHAR_CYC - 1);
  wire [7:0] lrc_out  = 8'(8'h00 - tlrc_reg); // RL2
  wire [7:0] sel      = st_reg == T_ADR ? adr_reg : st_reg == T_BODY ? PAY_BYTE :
                        st_reg == T_CHK0 ? (MODE_BIN ? tcrc_reg[7:0] : lrc_out) : tcrc_reg[15:8]; // RL8
  wire [7:0] cur      = tnib_reg ? hold_reg : sel;
  wire       cur_last = tnib_reg ? hold_last_reg : PAY_LAST;
  wire [7:0] tx_chr   = MODE_BIN ? cur : mbf_hex_chr(tnib_reg ? cur[3:0] : cur[7:4]); // RL2
  wire       data_st  = st_reg == T_ADR || st_reg == T_BODY || st_reg == T_CHK0 || st_reg == T_CHK1;

  always_ff @(posedge CLK) begin
    if (!RST_N || st_reg == T_IDLE || tick) begin
      div_reg <= 32'h0;
    end else begin
      div_reg <= div_reg + 32'h1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st_reg        <= T_IDLE;
      tnib_reg      <= 1'b0;
      hold_reg      <= 8'h00;
      hold_last_reg <= 1'b0;
      adr_reg       <= 8'h00;
      tcrc_reg      <= `MBF_CRC_INIT;
      tlrc_reg      <= 8'h00;
      gap_reg       <= 3'h0;
      h2d_data_reg  <= 8'h00;
      h2d_stb_reg   <= 1'b0;
      PAY_TAKE      <= 1'b0;
      TX_BUSY       <= 1'b0;
    end else begin
      h2d_stb_reg <= 1'b0;
      PAY_TAKE    <= 1'b0;
      TX_BUSY     <= st_reg != T_IDLE || SEND;
      if (st_reg == T_IDLE) begin
        if (SEND) begin
          adr_reg  <= SEND_ADDR;
          tnib_reg <= 1'b0;
          tcrc_reg <= `MBF_CRC_INIT; // RL3
          tlrc_reg <= 8'h00;
          st_reg   <= MODE_BIN ? T_ADR : T_START;
        end
      end else if (tick && st_reg == T_START) begin
        h2d_stb_reg  <= 1'b1;
        h2d_data_reg <= `MBF_CH_START;
        st_reg       <= T_ADR;
      end else if (tick && st_reg == T_END && !MODE_BIN) begin
        h2d_stb_reg  <= 1'b1;
        h2d_data_reg <= tnib_reg ? `MBF_CH_LF : `MBF_CH_CR; // RL9
        tnib_reg     <= !tnib_reg;
        st_reg       <= tnib_reg ? T_IDLE : T_END;
      end else if (tick && st_reg == T_END) begin
        gap_reg <= 3'(gap_reg + 3'h1);
        if (gap_reg == 3'(`MBF_IDLE_CHARS - 1)) begin // RL10
          gap_reg <= 3'h0;
          st_reg  <= T_IDLE;
        end
      end else if (tick && data_st) begin
        h2d_stb_reg  <= 1'b1;
        h2d_data_reg <= tx_chr;
        if (!tnib_reg) begin
          hold_reg      <= sel;
          hold_last_reg <= PAY_LAST;
          PAY_TAKE      <= st_reg == T_BODY;
        end
        if (!MODE_BIN) begin
          tnib_reg <= !tnib_reg;
        end
        if (MODE_BIN || tnib_reg) begin
          if (st_reg == T_ADR || st_reg == T_BODY) begin
            tcrc_reg <= mbf_crc_byte(tcrc_reg, cur); // RL7
            tlrc_reg <= 8'(tlrc_reg + cur); // RL1
          end
          case (st_reg)
            T_ADR:   st_reg <= T_BODY;
            T_BODY:  st_reg <= cur_last ? T_CHK0 : T_BODY;
            T_CHK0:  st_reg <= MODE_BIN ? T_CHK1 : T_END;
            default: st_reg <= T_END;
          endcase
        end
      end
    end
  end

  assign LINK.h2d_data = h2d_data_reg;
  assign LINK.h2d_stb  = h2d_stb_reg;
endmodule

// ### logic/mbf_link_if.sv
// Byte link between host controller end and device end
`timescale 1ns/1ns
interface mbf_link_if;
  logic [7:0] h2d_data;
  logic       h2d_stb;
  logic [7:0] d2h_data;
  logic       d2h_stb;

  modport dev  (input h2d_data, input h2d_stb, output d2h_data, output d2h_stb);
  modport host (output h2d_data, output h2d_stb, input d2h_data, input d2h_stb);
endinterface

// ### logic/mbf_pkg.sv
// Types and check functions shared by both ends
package mbf_pkg;
  `include "mbf_regs.svh"

  typedef logic [7:0] mbf_byte_t;

  // ----------------------------------------
  // Transmit sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    T_IDLE  = 3'h0,
    T_WAIT  = 3'h1,
    T_START = 3'h3,
    T_ADR   = 3'h2,
    T_BODY  = 3'h6,
    T_CHK0  = 3'h7,
    T_CHK1  = 3'h5,
    T_END   = 3'h4
  } mbf_tx_t;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [15:0] mbf_crc_byte(input logic [15:0] crc_in, input logic [7:0] b);
    logic [15:0] c;
    c = crc_in ^ {8'h00, b}; // RL4
    for (int i = 0; i < `MBF_CRC_STEPS; i++) begin // RL6
      c = c[0] ? ((c >> 1) ^ `MBF_CRC_POLY) : (c >> 1); // RL5
    end
    return c;
  endfunction

  function automatic logic [4:0] mbf_hex_val(input logic [7:0] c);
    logic [4:0] v;
    v = 5'h00;
    if (c >= `MBF_CH_0 && c <= `MBF_CH_0 + 8'h09) begin
      v = {1'b1, c[3:0]};
    end else if (c >= `MBF_CH_A && c <= `MBF_CH_A + 8'h05) begin
      v = {1'b1, 4'(c[3:0] + 4'h9)};
    end
    return v;
  endfunction

  function automatic logic [7:0] mbf_hex_chr(input logic [3:0] n);
    return {4'h0, n} + ((n < 4'ha) ? `MBF_CH_0 : (`MBF_CH_A - 8'h0a));
  endfunction
endpackage

// ### logic/mbf_regs.svh
// Framing constants for the serial frame checker and its host end
`ifndef MBF_REGS_SVH
`define MBF_REGS_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define MBF_CLK_HZ      50000000
`define MBF_BAUD        9600
`define MBF_CHAR_BITS   11
`define MBF_IDLE_CHARS  4
// ----------------------------------------
// Check values
// ----------------------------------------
`define MBF_CRC_INIT    16'hffff
`define MBF_CRC_POLY    16'ha001
`define MBF_CRC_STEPS   8
`define MBF_MIN_BIN     4
`define MBF_MIN_CHR     3
// ----------------------------------------
// Characters, codes and buffer size
// ----------------------------------------
`define MBF_CH_START    8'h3a
`define MBF_CH_CR       8'h0d
`define MBF_CH_LF       8'h0a
`define MBF_CH_0        8'h30
`define MBF_CH_A        8'h41
`define MBF_EXC_FLAG    8'h80
`define MBF_BCAST       8'h00
`define MBF_ADR_MAX     8'hfe
`define MBF_FN_READ     8'h03
`define MBF_ERR_NONE    8'h00
`define MBF_ERR_FUNC    8'h01
`define MBF_ERR_ADDR    8'h02
`define MBF_ERR_VALUE   8'h03
`define MBF_ERR_FAIL    8'h04
`define MBF_MAX_BYTES   32
`endif

// ### verif/mbf_link_chk.sv
// Link checker for the byte link between host end and device end
`timescale 1ns/1ns
module mbf_link_chk #(
  parameter int CC = 8
) (
  input wire logic       CLK,
  input wire logic       RST_N,
  input wire logic       MODE_BIN,
  input wire logic [7:0] h2d_data,
  input wire logic       h2d_stb,
  input wire logic [7:0] d2h_data,
  input wire logic       d2h_stb
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  function automatic logic chr_ok(input logic [7:0] c);
    return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46) || c == 8'h3a || c == 8'h0d || c == 8'h0a;
  endfunction

  sequence s_h_lf;
    ##CC (h2d_stb && h2d_data == 8'h0a);
  endsequence
  sequence s_d_lf;
    ##CC (d2h_stb && d2h_data == 8'h0a);
  endsequence

  AST_H_GAP: assert property (h2d_stb |=> !h2d_stb [*7])
    else $error("host characters too close");
  AST_D_GAP: assert property (d2h_stb |=> !d2h_stb [*7])
    else $error("device characters too close");
  AST_H_CRLF: assert property (h2d_stb && !MODE_BIN && h2d_data == 8'h0d |-> s_h_lf)
    else $error("host CR not followed by LF");
  AST_D_CRLF: assert property (d2h_stb && !MODE_BIN && d2h_data == 8'h0d |-> s_d_lf)
    else $error("device CR not followed by LF");
  AST_H_LF: assert property (h2d_stb && !MODE_BIN && h2d_data == 8'h0a |-> $past(h2d_data, CC) == 8'h0d)
    else $error("host LF without CR");
  AST_D_LF: assert property (d2h_stb && !MODE_BIN && d2h_data == 8'h0a |-> $past(d2h_data, CC) == 8'h0d)
    else $error("device LF without CR");
  AST_H_CHR: assert property (h2d_stb && !MODE_BIN |-> chr_ok(h2d_data))
    else $error("host illegal character");
  AST_D_CHR: assert property (d2h_stb && !MODE_BIN |-> chr_ok(d2h_data))
    else $error("device illegal character");
endmodule

// ### verif/test_modbus_frame_check_and_error_reply.sv
// Testbench joining host end and device end
`timescale 1ns/1ns
module test_modbus_frame_check_and_error_reply;
  import mbf_pkg::*;
  localparam int CC = 8;
  logic      CLK, RST_N, MODE_BIN, SEND, REPLY_GO, h_last, d_last, f_ok, need, f_err;
  logic      h_take, d_take, h_busy, d_busy, rx_stb, rx_done, rx_good;
  mbf_byte_t own, h_adr, h_pay, d_pay, code, rd_byte, rx_byte;
  logic [4:0] rd_idx;
  logic [5:0] f_len, rx_len;
  mbf_byte_t b[5];
  mbf_byte_t exp_q[$];
  int        fails, n_tests, k, cyc, seed, oks, exp_len;

  mbf_link_if mbf_link_if_i ();
  mbf_dev_end #(.CHAR_CYC(CC)) mbf_dev_end_i (.CLK(CLK), .RST_N(RST_N), .MODE_BIN(MODE_BIN), .OWN_ADDR(own),
    .RD_IDX(rd_idx), .REPLY_GO(REPLY_GO), .REPLY_CODE(code), .PAY_BYTE(d_pay), .PAY_LAST(d_last), .FRAME_OK(f_ok),
    .NEED_REPLY(need), .FRAME_ERR(f_err), .FRAME_LEN(f_len), .RD_BYTE(rd_byte), .PAY_TAKE(d_take),
    .TX_BUSY(d_busy), .LINK(mbf_link_if_i.dev));
  mbf_host_end #(.CHAR_CYC(CC)) mbf_host_end_i (.CLK(CLK), .RST_N(RST_N), .MODE_BIN(MODE_BIN), .SEND(SEND),
    .SEND_ADDR(h_adr), .PAY_BYTE(h_pay), .PAY_LAST(h_last), .PAY_TAKE(h_take), .TX_BUSY(h_busy), .RX_STB(rx_stb),
    .RX_BYTE(rx_byte), .RX_DONE(rx_done), .RX_GOOD(rx_good), .RX_LEN(rx_len), .LINK(mbf_link_if_i.host));
  mbf_link_chk #(.CC(CC)) mbf_link_chk_i (.CLK(CLK), .RST_N(RST_N), .MODE_BIN(MODE_BIN),
    .h2d_data(mbf_link_if_i.h2d_data), .h2d_stb(mbf_link_if_i.h2d_stb), .d2h_data(mbf_link_if_i.d2h_data),
    .d2h_stb(mbf_link_if_i.d2h_stb));

  function automatic logic [15:0] crc16(input logic [15:0] c, input mbf_byte_t x);
    c = c ^ {8'h00, x};
    repeat (8)
      c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    return c;
  endfunction

  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      fails++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  task automatic close_out;
    $display("fails %0d n_tests %0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic txn(input logic bin, input mbf_byte_t a, input mbf_byte_t f, input mbf_byte_t c);
    mbf_byte_t r[$];
    logic [15:0] crc;
    mbf_byte_t sum;
    MODE_BIN = bin;
    b[0] = f;
    for (int i = 1; i < 5; i++)
      b[i] = 8'($random(seed));
    k = 0;
    h_pay = f;
    h_last = 1'b0;
    d_pay = 8'($random(seed));
    code = c;
    oks = 0;
    h_adr = a;
    SEND = 1'b1;
    @(negedge CLK) SEND = 1'b0;
    @(negedge CLK);
    while (h_busy) @(negedge CLK);
    repeat (6 * CC) @(negedge CLK);
    chk(oks === int'(a == own || a == 8'h00), "frame acceptance");
    chk(need === (a == own), "reply wanted");
    if (need === 1'b1) begin
      if (c != 8'h00) r = {a, f | 8'h80, c};
      else r = {a, f, d_pay};
      crc = 16'hffff;
      sum = 8'h00;
      foreach (r[i]) begin
        crc = crc16(crc, r[i]);
        sum += r[i];
      end
      if (bin) exp_q = {r, crc[7:0], crc[15:8]};
      else exp_q = {r, 8'(-sum)};
      exp_len = exp_q.size();
      REPLY_GO = 1'b1;
      @(negedge CLK) REPLY_GO = 1'b0;
      @(negedge CLK);
      while (d_busy) @(negedge CLK);
      repeat (6 * CC) @(negedge CLK);
      chk(exp_q.size() == 0, "reply incomplete");
    end
  endtask

  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  always @(negedge CLK) if (h_take) begin
    k++;
    h_pay = b[k];
    h_last = (k == 4);
  end

  always @(posedge CLK) begin
    if (rx_stb) begin
      chk(rx_byte === exp_q[0], "reply byte");
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
    if (rx_done) chk(rx_good === 1'b1 && rx_len == 6'(exp_len), "reply check");
    if (f_err || f_ok) chk(f_err === 1'b0, "good frame dropped");
    if (f_ok) begin
      oks++;
      chk(f_len === 6'h06 && rd_byte === b[0], "stored frame");
    end
    if (++cyc > 40000) begin
      fails++;
      close_out();
    end
  end

  initial begin
    seed = 10;
    fails = 0;
    n_tests = 0;
    cyc = 0;
    {RST_N, SEND, REPLY_GO, h_last, code, h_adr, h_pay, d_pay} = '0;
    MODE_BIN = 1'b1;
    own = 8'hfe;
    d_last = 1'b1;
    rd_idx = 5'h01;
    repeat (2) @(negedge CLK);
    RST_N = 1'b1;
    for (int m = 0; m < 2; m++) begin
      for (int c = 0; c < 5; c++)
        txn(m == 0, own, c ? 8'($random(seed)) & 8'h7f : 8'h06, 8'(c));
      txn(m == 0, 8'h00, 8'h06, 8'h00);
      txn(m == 0, 8'hff, 8'h06, 8'h00);
    end
    close_out();
  end
endmodule
